// >>> iso_rx_pkg.sv
// package: offsets, field positions, states and carriers of the receive start filter
package iso_rx_pkg;
  localparam int NUM_CTX = 4;
  localparam logic [15:0] CMD_PTR_BASE = 16'h040C;
  localparam logic [15:0] MATCH_BASE = 16'h410C;
  localparam logic [15:0] CTX_STRIDE = 16'h0020;
  localparam int TAG_EN_HI = 31;
  localparam int TAG_EN_LO = 28;
  localparam int RESERVED_BIT = 27;
  localparam int START_HI = 26;
  localparam int START_LO = 12;
  localparam int SYNC_HI = 11;
  localparam int SYNC_LO = 8;
  localparam int RESERVED_LOW_BIT = 7;
  localparam int TAG01_SYNC_FILT = 6;
  localparam int CHAN_HI = 5;
  localparam int CHAN_LO = 0;
  localparam int CT_SEC_LO = 25;
  localparam int CT_CNT_LO = 12;
  localparam logic [31:0] MATCH_RESET = 32'h0000_0000;
  localparam logic [31:0] MATCH_WMASK = 32'hF7FF_FF7F;
  localparam logic [1:0] TAG_SYNC_FILT = 2'h1;
  localparam logic [1:0] SYNC_TOP_REQ = 2'h0;

  typedef enum logic [1:0] {
    CTX_IDLE = 2'b00,
    CTX_WAIT_CYCLE = 2'b01,
    CTX_WAIT_SYNC = 2'b10,
    CTX_RECEIVE = 2'b11
  } ctx_state_t;

  typedef struct packed {
    logic valid;
    logic [5:0] channel;
    logic [1:0] tag;
    logic [3:0] sync;
  } pkt_hdr_t;

  typedef struct packed {
    logic valid;
    logic [1:0] ctx;
    logic [31:0] addr;
  } fetch_req_t;
endpackage : iso_rx_pkg

// >>> iso_rx_context_start_filter.sv
// four isochronous receive contexts: first-descriptor fetch, start cycle, sync wait, tag filter
// Behaviour
// - raising a context's run bit requests a fetch from its descriptor pointer
// - four contexts; pointer register at 40Ch plus 32 per context, read-only
// - match register per context at 410Ch plus 32 per context
// - match register can hold reception back until a chosen bus cycle
// - when asked, context waits for a packet with the programmed sync value
// - bit 31 set accepts packets with tag 11b
// - bit 30 set accepts packets with tag 10b
// - bit 29 set accepts packets with tag 01b
// - bit 28 set accepts packets with tag 00b
// - match bit 27 always reads as zero
// - run bit is owned by software; device never changes it
// - start when timer seconds low bits and cycle count equal start field
// - sync field bits 11 to 8 compared against packet sync when wait is 11b
`timescale 1ns/100ps
module iso_rx_context_start_filter (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [15:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // joining signals from control register and descriptor engine
  input wire logic [3:0] runBit,
  input wire logic [3:0] cycleMatchEn,
  input wire logic [3:0] waitSyncEn,
  input wire logic softReset,
  input wire logic [31:0] cmdPtr [4],
  // cycle timer
  input wire logic [31:0] cycleTimer,
  // packet headers from the link
  input wire iso_rx_pkg::pkt_hdr_t pktHdr,
  // descriptor fetch request
  output iso_rx_pkg::fetch_req_t fetchReq,
  input wire logic fetchReady,
  // per-context status
  output logic [3:0] pktAccept,
  output logic [3:0] ctxReceiving
);

  logic ack_r;
  logic [31:0] datO_r;
  logic wbReq;
  logic wbWrEn;
  logic [31:0] byteMask;
  logic [31:0] rdHit [4];
  logic [31:0] rdData;
  logic [31:0] match_r [4];
  logic [3:0] runPrev_r;
  logic [3:0] runRise;
  logic [3:0] pend_r;
  logic [31:0] ptrHold_r [4];
  iso_rx_pkg::fetch_req_t fetch_r;
  logic [3:0] grant;
  logic [1:0] grantIdx;
  logic [3:0] accept_r;
  logic [3:0] pass;
  logic [14:0] timerNow;

  assign wbReq = wbCyc & wbStb;
  // write lands at the edge where the master sees ack
  assign wbWrEn = wbReq & wbWe & ack_r;
  assign wbAck = ack_r;
  assign wbDatO = datO_r;
  assign fetchReq = fetch_r;
  assign pktAccept = accept_r;
  assign timerNow = {cycleTimer[iso_rx_pkg::CT_SEC_LO +: 2],
                     cycleTimer[iso_rx_pkg::CT_CNT_LO +: 13]};

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byteMask[b*8 +: 8] = {8{wbSel[b]}};
    end
  end

  // one wait state; ack drops the cycle after it was given
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wbReq & ~ack_r;
    end
  end

  always_comb begin
    rdData = 32'h0000_0000;
    for (int n = 0; n < iso_rx_pkg::NUM_CTX; n++) begin
      rdData = rdData | rdHit[n];
    end
  end

  // unmapped addresses read zero and ignore writes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      datO_r <= 32'h0000_0000;
    end else if (wbReq & ~ack_r) begin
      datO_r <= rdData;
    end
  end

  always_comb begin
    runRise = runBit & ~runPrev_r;
  end

  // device only watches run, it never drives it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      runPrev_r <= 4'h0;
    end else begin
      runPrev_r <= runBit;
    end
  end

  // lowest context wins the fetch port
  always_comb begin
    grant = 4'h0;
    grantIdx = 2'h0;
    for (int n = iso_rx_pkg::NUM_CTX - 1; n >= 0; n--) begin
      if (pend_r[n]) begin
        grant = 4'h0;
        grant[n] = 1'b1;
        grantIdx = 2'(n);
      end
    end
  end

  // output stage holds the request until the engine takes it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fetch_r <= '0;
    end else if (softReset) begin
      fetch_r <= '0;
    end else if (!fetch_r.valid || fetchReady) begin
      fetch_r.valid <= |pend_r;
      fetch_r.ctx <= grantIdx;
      fetch_r.addr <= ptrHold_r[grantIdx];
    end
  end

  genvar g;
  generate
    for (g = 0; g < iso_rx_pkg::NUM_CTX; g++) begin : gCtx
      localparam logic [15:0] PTR_ADR =
        16'(iso_rx_pkg::CMD_PTR_BASE + iso_rx_pkg::CTX_STRIDE * g);
      localparam logic [15:0] MATCH_ADR =
        16'(iso_rx_pkg::MATCH_BASE + iso_rx_pkg::CTX_STRIDE * g);
      iso_rx_pkg::ctx_state_t state_r;
      iso_rx_pkg::ctx_state_t state_nxt;
      logic hitPtr;
      logic hitMatch;
      logic chanOk;
      logic syncOk;
      logic tagOk;
      logic syncFiltOk;
      logic cycleHit;
      logic canTake;
      logic [31:0] matchRd;

      assign hitPtr = wbAdr[15:2] == PTR_ADR[15:2];
      assign hitMatch = wbAdr[15:2] == MATCH_ADR[15:2];

      // reserved bits forced low whatever was written
      always_comb begin
        matchRd = match_r[g];
        matchRd[iso_rx_pkg::RESERVED_BIT] = 1'b0;
        matchRd[iso_rx_pkg::RESERVED_LOW_BIT] = 1'b0;
      end

      always_comb begin
        rdHit[g] = 32'h0000_0000;
        if (hitPtr) begin
          rdHit[g] = cmdPtr[g];
        end else if (hitMatch) begin
          rdHit[g] = matchRd;
        end
      end

      // pointer register is read-only: bus writes never reach it
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          match_r[g] <= iso_rx_pkg::MATCH_RESET;
        end else if (wbWrEn && hitMatch) begin
          match_r[g] <= (match_r[g] & ~(byteMask & iso_rx_pkg::MATCH_WMASK))
                      | (wbDatI & byteMask & iso_rx_pkg::MATCH_WMASK);
        end
      end

      // pointer captured at start so a later change cannot skew the fetch
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          ptrHold_r[g] <= 32'h0000_0000;
        end else if (runRise[g]) begin
          ptrHold_r[g] <= cmdPtr[g];
        end
      end

      // a new start wins over the grant clearing the same bit
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          pend_r[g] <= 1'b0;
        end else if (softReset) begin
          pend_r[g] <= 1'b0;
        end else if (runRise[g]) begin
          pend_r[g] <= 1'b1;
        end else if (grant[g] && (!fetch_r.valid || fetchReady)) begin
          pend_r[g] <= 1'b0;
        end
      end

      assign cycleHit = timerNow ==
        match_r[g][iso_rx_pkg::START_HI:iso_rx_pkg::START_LO];
      assign chanOk = pktHdr.valid &&
        pktHdr.channel == match_r[g][iso_rx_pkg::CHAN_HI:iso_rx_pkg::CHAN_LO];
      assign syncOk = pktHdr.sync ==
        match_r[g][iso_rx_pkg::SYNC_HI:iso_rx_pkg::SYNC_LO];

      // each tag value has its own enable; all clear accepts nothing
      always_comb begin
        unique case (pktHdr.tag)
          2'h3: tagOk = match_r[g][31];
          2'h2: tagOk = match_r[g][30];
          2'h1: tagOk = match_r[g][29];
          2'h0: tagOk = match_r[g][28];
        endcase
      end

      assign syncFiltOk = !(match_r[g][iso_rx_pkg::TAG01_SYNC_FILT] &&
        pktHdr.tag == iso_rx_pkg::TAG_SYNC_FILT) ||
        pktHdr.sync[3:2] == iso_rx_pkg::SYNC_TOP_REQ;

      always_comb begin
        state_nxt = state_r;
        canTake = 1'b0;
        unique case (state_r)
          iso_rx_pkg::CTX_IDLE: begin
            if (runRise[g]) begin
              if (cycleMatchEn[g]) begin
                state_nxt = iso_rx_pkg::CTX_WAIT_CYCLE;
              end else if (waitSyncEn[g]) begin
                state_nxt = iso_rx_pkg::CTX_WAIT_SYNC;
              end else begin
                state_nxt = iso_rx_pkg::CTX_RECEIVE;
              end
            end
          end
          iso_rx_pkg::CTX_WAIT_CYCLE: begin
            if (cycleHit) begin
              state_nxt = waitSyncEn[g] ? iso_rx_pkg::CTX_WAIT_SYNC
                                        : iso_rx_pkg::CTX_RECEIVE;
            end
          end
          iso_rx_pkg::CTX_WAIT_SYNC: begin
            // the packet that carries the sync is itself taken
            if (chanOk && syncOk) begin
              state_nxt = iso_rx_pkg::CTX_RECEIVE;
              canTake = 1'b1;
            end
          end
          iso_rx_pkg::CTX_RECEIVE: begin
            canTake = 1'b1;
          end
        endcase
        if (!runBit[g]) begin
          state_nxt = iso_rx_pkg::CTX_IDLE;
          canTake = 1'b0;
        end
      end

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          state_r <= iso_rx_pkg::CTX_IDLE;
        end else if (softReset) begin
          state_r <= iso_rx_pkg::CTX_IDLE;
        end else begin
          state_r <= state_nxt;
        end
      end

      assign pass[g] = canTake && chanOk && tagOk && syncFiltOk;

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          accept_r[g] <= 1'b0;
          ctxReceiving[g] <= 1'b0;
        end else begin
          accept_r[g] <= pass[g] & ~softReset;
          ctxReceiving[g] <= state_nxt == iso_rx_pkg::CTX_RECEIVE && !softReset;
        end
      end
    end
  endgenerate

endmodule : iso_rx_context_start_filter

// >>> iso_rx_context_start_filter_properties.sv
// checker: port-level properties of the receive start filter
`timescale 1ns/100ps
module iso_rx_context_start_filter_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // bus and joining signals
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  input wire logic [15:0] wbAdr,
  input wire logic [31:0] wbDatO,
  input wire logic [3:0] runBit,
  input wire logic [3:0] cycleMatchEn,
  input wire logic [3:0] waitSyncEn,
  input wire logic softReset,
  input wire iso_rx_pkg::pkt_hdr_t pktHdr,
  input wire iso_rx_pkg::fetch_req_t fetchReq,
  input wire logic fetchReady,
  input wire logic [3:0] pktAccept,
  input wire logic [3:0] ctxReceiving
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ack_one_cycle_a: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
  ack_wait_state_a: assert property (wbCyc && wbStb && !wbAck && !$past(wbAck) |=> wbAck)
    else $error("ack not after one wait state");
  reserved_reads_a: assert property (wbAck && wbAdr[14] |-> !wbDatO[27] && !wbDatO[7])
    else $error("reserved match bit read nonzero");
  fetch_start_a: assert property ($rose(runBit[0]) |-> ##[1:8] fetchReq.valid)
    else $error("no fetch after run");
  fetch_hold_a: assert property (fetchReq.valid && !fetchReady && !softReset
    |=> fetchReq.valid && $stable(fetchReq.addr)) else $error("fetch dropped");
  accept_cause_a: assert property (pktAccept != 4'h0 |-> $past(pktHdr.valid))
    else $error("accept without packet");
  run_stop_a: assert property (!runBit[0] |=> !ctxReceiving[0]) else $error("stopped ctx receives");
  cycle_hold_a: assert property ($rose(runBit[1]) && cycleMatchEn[1] |=> !ctxReceiving[1])
    else $error("cycle wait skipped");
endmodule : iso_rx_context_start_filter_properties

bind iso_rx_context_start_filter iso_rx_context_start_filter_properties u_props (
  .core_clk(core_clk), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
  .wbAdr(wbAdr), .wbDatO(wbDatO), .runBit(runBit), .cycleMatchEn(cycleMatchEn),
  .waitSyncEn(waitSyncEn), .softReset(softReset), .pktHdr(pktHdr), .fetchReq(fetchReq),
  .fetchReady(fetchReady), .pktAccept(pktAccept), .ctxReceiving(ctxReceiving)
);

// >>> iso_pkt_source.sv
// partner: isochronous packet header source on the link side
`timescale 1ns/100ps
module iso_pkt_source (
  // clock
  input wire logic core_clk,
  // header out
  output iso_rx_pkg::pkt_hdr_t hdr
);
  initial hdr = '0;
  // one-cycle header; fields invert afterwards so stale values never look valid
  task automatic send(input logic [5:0] ch, input logic [1:0] tg, input logic [3:0] sy);
    @(posedge core_clk);
    hdr <= '{1'b1, ch, tg, sy};
    @(posedge core_clk);
    hdr <= '{1'b0, ~ch, ~tg, ~sy};
  endtask : send
endmodule : iso_pkt_source

// >>> iso_rx_context_start_filter_test.sv
// testbench: registers, tag filter, sync wait, cycle start, fetch
`timescale 1ns/100ps
module iso_rx_context_start_filter_test;
  logic core_clk, nrst, wbCyc, wbStb, wbWe, wbAck, softReset, fetchReady;
  logic [15:0] wbAdr;
  logic [3:0] wbSel, runBit, cycleMatchEn, waitSyncEn, pktAccept, ctxReceiving;
  logic [31:0] wbDatI, wbDatO, cycleTimer, rd;
  logic [31:0] cmdPtr [4];
  iso_rx_pkg::pkt_hdr_t pktHdr;
  iso_rx_pkg::fetch_req_t fetchReq;
  int bad_count, checks;
  typedef struct {logic [31:0] m; logic [1:0] tg; logic [3:0] sy; logic ex;} row_t;
  row_t rows [7] = '{'{32'h8000_0005, 2'h3, 4'h0, 1'b1}, '{32'h4000_0005, 2'h2, 4'h0, 1'b1},
    '{32'h2000_0005, 2'h1, 4'h0, 1'b1}, '{32'h1000_0005, 2'h0, 4'h0, 1'b1},
    '{32'h0000_0005, 2'h0, 4'h0, 1'b0}, '{32'h7000_0005, 2'h3, 4'h0, 1'b0},
    '{32'h2000_0045, 2'h1, 4'hC, 1'b0}};
  iso_rx_context_start_filter u_iso_rx_context_start_filter (.core_clk(core_clk), .nrst(nrst),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAck(wbAck), .runBit(runBit), .cycleMatchEn(cycleMatchEn),
    .waitSyncEn(waitSyncEn), .softReset(softReset), .cmdPtr(cmdPtr), .cycleTimer(cycleTimer),
    .pktHdr(pktHdr), .fetchReq(fetchReq), .fetchReady(fetchReady), .pktAccept(pktAccept),
    .ctxReceiving(ctxReceiving));
  iso_pkt_source u_iso_pkt_source (.core_clk(core_clk), .hdr(pktHdr));
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] ex);
    checks++;
    if (got !== ex) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : check
  // classic single cycle; hold until ack, release after
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} <= {2'h3, w, a, d, 4'hF};
    do @(posedge core_clk); while (wbAck !== 1'b1);
    rd = wbDatO;
    {wbCyc, wbStb} <= 2'h0;
    @(posedge core_clk);
  endtask : wb
  task automatic pkt(input logic [1:0] tg, input logic [3:0] sy);
    u_iso_pkt_source.send(6'h05, tg, sy);
    @(posedge core_clk);
  endtask : pkt
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
  initial begin
    {nrst, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI, softReset} = '0;
    {runBit, cycleMatchEn, waitSyncEn, cycleTimer} = '0;
    fetchReady = 1'b1;
    cmdPtr = '{32'h1111_2220, 32'h3333_4440, 32'h5555_6660, 32'h7777_8880};
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      wb(1'b0, iso_rx_pkg::MATCH_BASE + 16'(32 * n), 32'h0);
      check("match reset", rd, 32'h0);
      wb(1'b0, 16'h040C + 16'(32 * n), 32'h0);
      check("pointer", rd, cmdPtr[n]);
    end
    wb(1'b1, 16'h040C, 32'h0);
    wb(1'b0, 16'h040C, 32'h0);
    check("pointer ro", rd, cmdPtr[0]);
    wb(1'b1, 16'h412C, 32'hFFFF_FFFF);
    wb(1'b0, 16'h412C, 32'h0);
    check("match rw", rd, 32'hF7FF_FF7F);
    wb(1'b0, 16'h0800, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test registers done");
    runBit[0] <= 1'b1;
    foreach (rows[i]) begin
      wb(1'b1, 16'h410C, rows[i].m);
      pkt(rows[i].tg, rows[i].sy);
      check("tag filter", pktAccept[0], rows[i].ex);
    end
    $display("test tag filter done");
    wb(1'b1, 16'h416C, 32'h8000_0905);
    waitSyncEn[3] <= 1'b1;
    runBit[3] <= 1'b1;
    pkt(2'h3, 4'h2);
    check("sync wait", pktAccept[3], 1'b0);
    pkt(2'h3, 4'h9);
    check("sync hit", pktAccept[3], 1'b1);
    pkt(2'h3, 4'h2);
    check("after sync", pktAccept[3], 1'b1);
    $display("test sync done");
    wb(1'b1, 16'h412C, 32'h85A5_A005);
    cycleTimer <= 32'h05A5_9000;
    cycleMatchEn[1] <= 1'b1;
    runBit[1] <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("cycle held", ctxReceiving[1], 1'b0);
    cycleTimer <= 32'hF5A5_A000;
    repeat (3) @(posedge core_clk);
    check("cycle start", ctxReceiving[1], 1'b1);
    $display("test cycle start done");
    fetchReady <= 1'b0;
    runBit[2] <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("fetch", {fetchReq.valid, 5'(fetchReq.ctx)}, 6'h22);
    check("fetch addr", fetchReq.addr, cmdPtr[2]);
    fetchReady <= 1'b1;
    repeat (2) @(posedge core_clk);
    $display("test fetch done");
    softReset <= 1'b1;
    @(posedge core_clk);
    softReset <= 1'b0;
    @(posedge core_clk);
    check("soft reset idle", ctxReceiving, 4'h0);
    wb(1'b0, 16'h416C, 32'h0);
    check("soft reset keeps match", rd, 32'h8000_0905);
    $display("test soft reset done");
    conclude();
  end
endmodule : iso_rx_context_start_filter_test
